/* rtl/deil_pkg.sv */
/*
  Constants for the dual external interrupt latch: register offsets,
  field positions and reset values.
  Assumes an 8-bit register port and a 125 MHz ref_clk.
*/
// Operation
// [R01] Fresh falling edge after acknowledge relatches pin one
// [R02] Level mode holds pin one request while low
// [R03] Level mode clears after acknowledge and pin high
// [R04] Reset clears requests and trigger selects
// [R05] Edge mode: acknowledge clears pin one at once
// [R06] Pin one flag readable regardless of mask
// [R07] Pin one level offered to branch instructions
// [R08] Pin two latches; fetch, acknowledge, reset clear
// [R09] Pin two acknowledge spares later edges
// [R10] Unmasked pin two request reaches the CPU
// [R11] Level mode holds pin two while low
// [R12] Edge mode: acknowledge clears pin two at once
// [R13] Pin two flag independent of mask
// [R14] Pin two level hidden; flag mirrors it
// [R15] Unmasked request wakes from wait
// [R16] Unmasked request wakes from stop
// [R17] Break clear enable lets acknowledges clear
// [R18] Break without enable ignores acknowledges
// [R19] Acknowledge bits write-only, read zero
// [R20] Mask bits read/write, reset clear
// [R21] Trigger selects read/write, reset clear
// [R22] Flags read-only, one while pending
// [R23] Masked requests never reach priority logic
// [R24] Each pin has its own latch
// [R25] Pins synchronised; fall is high then low
// [R26] New edge beats a same-cycle acknowledge
package deil_pkg;

  // Register port geometry
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [1:0] EXT_INT_STATUS_CONTROL_OFS = 2'h0;
  localparam logic [1:0] BREAK_FLAG_CONTROL_OFS     = 2'h1;

  // Status and control field positions
  localparam int TRIGGER_SELECT_ONE_POS = 0;
  localparam int REQUEST_MASK_ONE_POS   = 1;
  localparam int REQUEST_CLEAR_ONE_POS  = 2;
  localparam int PENDING_FLAG_ONE_POS   = 3;
  localparam int TRIGGER_SELECT_TWO_POS = 4;
  localparam int REQUEST_MASK_TWO_POS   = 5;
  localparam int REQUEST_CLEAR_TWO_POS  = 6;
  localparam int PENDING_FLAG_TWO_POS   = 7;

  // Break flag control field position
  localparam int BREAK_CLEAR_ENABLE_POS = 7;

  // Reset values and unmapped read value
  localparam logic       CTRL_BIT_RST  = 1'b0;
  localparam logic       PIN_IDLE_RST  = 1'b1;
  localparam logic [7:0] RD_DATA_RST   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

/* rtl/deil_pin_latch.sv */
/*
  One pin's request latch: two-stage synchroniser, falling edge
  detect and the request flip-flop with edge or edge-and-level sense.
  Assumes the pin is active low and asynchronous to ref_clk.
*/
`timescale 1ns/1ps

module deil_pin_latch (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic pin_n,
  input  wire logic level_mode,
  input  wire logic ack,
  output logic      pin_lvl_r,
  output logic      pin_prev_r,
  output logic      req_r
);

  logic meta_r;
  logic latch_r;
  logic fall;
  logic latch_nxt;
  logic req_nxt;

  // ************************************************
  // Synchroniser and edge history
  // ************************************************

  // Two flops before any logic, then one more for history
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r     <= deil_pkg::PIN_IDLE_RST;
      pin_lvl_r  <= deil_pkg::PIN_IDLE_RST;
      pin_prev_r <= deil_pkg::PIN_IDLE_RST;
    end else if (ce) begin
      meta_r     <= pin_n;
      pin_lvl_r  <= meta_r;
      pin_prev_r <= pin_lvl_r;
    end
  end

  // ************************************************
  // Request latch
  // ************************************************

  // Falling edge: sampled high then sampled low
  assign fall = pin_prev_r & ~pin_lvl_r; // R25

  // Edge latch, set wins; low level adds to it in level mode
  always_comb begin
    latch_nxt = fall | (latch_r & ~ack); // R26
    req_nxt   = latch_nxt | (level_mode & ~pin_lvl_r); // R02 R03
  end

  // Edge latch and request flops; ack and pin high in any order clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= deil_pkg::CTRL_BIT_RST;
      req_r   <= deil_pkg::CTRL_BIT_RST; // R04
    end else if (ce) begin
      latch_r <= latch_nxt;
      req_r   <= req_nxt; // R03
    end
  end

endmodule

/* rtl/deil_ext_int.sv */
/*
  Dual external interrupt latch top: register port, masks, trigger
  selects, break protection of acknowledges, CPU request and wake
  outputs, and the two pin latches.
  Assumes a register master on ref_clk with one-cycle strobes, vector
  fetch pulses and break state from CPU logic on the same clock.
*/
`timescale 1ns/1ps

module deil_ext_int (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       ext_int_pin_one_n,
  input  wire logic       ext_int_pin_two_n,
  input  wire logic [1:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  input  wire logic       vector_fetch_one,
  input  wire logic       vector_fetch_two,
  input  wire logic       break_state,
  output logic      [7:0] bus_rdata_r,
  output logic            cpu_req_one_r,
  output logic            cpu_req_two_r,
  output logic            wake_req_r,
  output logic            pin_one_level_r
);

  // ************************************************
  // Declarations
  // ************************************************

  logic       trigger_select_one_r;
  logic       trigger_select_two_r;
  logic       request_mask_one_r;
  logic       request_mask_two_r;
  logic       break_clear_enable_r;
  logic       pending_flag_one;
  logic       pending_flag_two;
  logic       lvl_one;
  logic       lvl_two;
  logic       prev_one;
  logic       prev_two;
  logic       fall_one;
  logic       fall_two;
  logic       wr_status;
  logic       wr_break;
  logic       sw_ack_ok;
  logic       request_clear_one;
  logic       request_clear_two;
  logic       ack_one;
  logic       ack_two;
  logic       wake_nxt;
  logic [7:0] status_view;
  logic [7:0] rd_nxt;

  // ************************************************
  // Write decode and acknowledge paths
  // ************************************************

  // Address decode of the two registers
  assign wr_status = bus_wr && (bus_addr == deil_pkg::EXT_INT_STATUS_CONTROL_OFS);
  assign wr_break  = bus_wr && (bus_addr == deil_pkg::BREAK_FLAG_CONTROL_OFS);

  // Software acknowledge allowed outside break or with clear enable
  assign sw_ack_ok = !break_state || break_clear_enable_r; // R17 R18

  // Write-only acknowledge strobes, never stored
  assign request_clear_one = wr_status && bus_wdata[deil_pkg::REQUEST_CLEAR_ONE_POS]; // R19
  assign request_clear_two = wr_status && bus_wdata[deil_pkg::REQUEST_CLEAR_TWO_POS]; // R19

  // Vector fetch or permitted software clear acknowledges
  assign ack_one = vector_fetch_one || (request_clear_one && sw_ack_ok); // R05
  assign ack_two = vector_fetch_two || (request_clear_two && sw_ack_ok); // R08 R12

  // ************************************************
  // Control bits
  // ************************************************

  // Trigger selects, cleared by reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_select_one_r <= deil_pkg::CTRL_BIT_RST; // R04
      trigger_select_two_r <= deil_pkg::CTRL_BIT_RST; // R04
    end else if (ce && wr_status) begin
      trigger_select_one_r <= bus_wdata[deil_pkg::TRIGGER_SELECT_ONE_POS]; // R21
      trigger_select_two_r <= bus_wdata[deil_pkg::TRIGGER_SELECT_TWO_POS]; // R21
    end
  end

  // Mask bits, cleared by reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      request_mask_one_r <= deil_pkg::CTRL_BIT_RST;
      request_mask_two_r <= deil_pkg::CTRL_BIT_RST;
    end else if (ce && wr_status) begin
      request_mask_one_r <= bus_wdata[deil_pkg::REQUEST_MASK_ONE_POS]; // R20
      request_mask_two_r <= bus_wdata[deil_pkg::REQUEST_MASK_TWO_POS]; // R20
    end
  end

  // Break clear enable, default zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      break_clear_enable_r <= deil_pkg::CTRL_BIT_RST; // R18
    end else if (ce && wr_break) begin
      break_clear_enable_r <= bus_wdata[deil_pkg::BREAK_CLEAR_ENABLE_POS];
    end
  end

  // ************************************************
  // Pin latches
  // ************************************************

  // Pin one latch, independent of pin two
  deil_pin_latch u_latch_one (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .pin_n      (ext_int_pin_one_n),
    .level_mode (trigger_select_one_r),
    .ack        (ack_one),
    .pin_lvl_r  (lvl_one),
    .pin_prev_r (prev_one),
    .req_r      (pending_flag_one)
  ); // R24

  // Pin two latch
  deil_pin_latch u_latch_two (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .pin_n      (ext_int_pin_two_n),
    .level_mode (trigger_select_two_r),
    .ack        (ack_two),
    .pin_lvl_r  (lvl_two),
    .pin_prev_r (prev_two),
    .req_r      (pending_flag_two)
  ); // R24

  // Edge seen by the latches, for checking
  assign fall_one = prev_one & ~lvl_one;
  assign fall_two = prev_two & ~lvl_two;

  // ************************************************
  // CPU request, wake and pin level outputs
  // ************************************************

  // Either unmasked request wakes from wait or stop
  assign wake_nxt = (pending_flag_one && !request_mask_one_r)
                  || (pending_flag_two && !request_mask_two_r); // R15 R16

  // Only unmasked requests reach the priority logic
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_req_one_r <= deil_pkg::CTRL_BIT_RST;
      cpu_req_two_r <= deil_pkg::CTRL_BIT_RST;
      wake_req_r    <= deil_pkg::CTRL_BIT_RST;
    end else if (ce) begin
      cpu_req_one_r <= pending_flag_one && !request_mask_one_r; // R01 R23
      cpu_req_two_r <= pending_flag_two && !request_mask_two_r; // R10 R23
      wake_req_r    <= wake_nxt; // R15 R16
    end
  end

  // Synchronised pin one level for branch tests
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_one_level_r <= deil_pkg::PIN_IDLE_RST;
    end else if (ce) begin
      pin_one_level_r <= lvl_one; // R07
    end
  end

  // ************************************************
  // Read path
  // ************************************************

  // Status view; acknowledge bits read zero
  always_comb begin
    status_view = deil_pkg::RD_DATA_RST;
    status_view[deil_pkg::TRIGGER_SELECT_ONE_POS] = trigger_select_one_r;
    status_view[deil_pkg::REQUEST_MASK_ONE_POS]   = request_mask_one_r;
    status_view[deil_pkg::PENDING_FLAG_ONE_POS]   = pending_flag_one; // R06 R22
    status_view[deil_pkg::TRIGGER_SELECT_TWO_POS] = trigger_select_two_r;
    status_view[deil_pkg::REQUEST_MASK_TWO_POS]   = request_mask_two_r;
    status_view[deil_pkg::PENDING_FLAG_TWO_POS]   = pending_flag_two; // R13 R14 R22
  end

  // Register select; unmapped reads return zero
  always_comb begin
    rd_nxt = deil_pkg::UNMAPPED_READ;
    case (bus_addr)
      deil_pkg::EXT_INT_STATUS_CONTROL_OFS: begin
        rd_nxt = status_view;
      end
      deil_pkg::BREAK_FLAG_CONTROL_OFS: begin
        rd_nxt[deil_pkg::BREAK_CLEAR_ENABLE_POS] = break_clear_enable_r;
      end
      default: begin
        rd_nxt = deil_pkg::UNMAPPED_READ;
      end
    endcase
  end

  // Read data valid in the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata_r <= deil_pkg::RD_DATA_RST;
    end else if (ce) begin
      if (bus_rd) begin
        bus_rdata_r <= rd_nxt;
      end else begin
        bus_rdata_r <= deil_pkg::RD_DATA_RST;
      end
    end
  end

  // ************************************************
  // Assertions
  // ************************************************

  // Pin one: falling edge latches a request
  property p_fall_one_latch; // R01
    @(posedge ref_clk) disable iff (!rst_n)
    ce && fall_one |=> pending_flag_one;
  endproperty
  a_fall_one_latch: assert property (p_fall_one_latch) // R25
    else $error("pin one edge not latched");

  // Pin one level mode holds while low
  property p_level_one_hold; // R02
    @(posedge ref_clk) disable iff (!rst_n)
    ce && trigger_select_one_r && !lvl_one |=> pending_flag_one;
  endproperty
  a_level_one_hold: assert property (p_level_one_hold) // R02
    else $error("pin one level request dropped");

  // Acknowledge with pin high clears next edge
  sequence s_ack_one_pin_high;
    ce && ack_one && lvl_one;
  endsequence
  property p_ack_one_clear; // R03
    @(posedge ref_clk) disable iff (!rst_n)
    s_ack_one_pin_high |=> !pending_flag_one;
  endproperty
  a_ack_one_clear: assert property (p_ack_one_clear) // R05
    else $error("pin one acknowledge ignored");

  // Pin two level mode survives acknowledge while low
  property p_level_two_hold; // R11
    @(posedge ref_clk) disable iff (!rst_n)
    ce && trigger_select_two_r && !lvl_two && ack_two |=> pending_flag_two;
  endproperty
  a_level_two_hold: assert property (p_level_two_hold) // R11
    else $error("pin two level request dropped");

  // Acknowledge then new edge relatches pin two
  sequence s_ack_then_fall_two;
    ce && ack_two && lvl_two ##1 ce && fall_two;
  endsequence
  property p_relatch_two; // R09
    @(posedge ref_clk) disable iff (!rst_n)
    s_ack_then_fall_two |=> pending_flag_two;
  endproperty
  a_relatch_two: assert property (p_relatch_two) // R08
    else $error("pin two edge after acknowledge lost");

  // Edge mode acknowledge clears pin two at once
  property p_edge_two_clear; // R12
    @(posedge ref_clk) disable iff (!rst_n)
    ce && !trigger_select_two_r && ack_two && !fall_two |=> !pending_flag_two;
  endproperty
  a_edge_two_clear: assert property (p_edge_two_clear) // R12
    else $error("pin two edge mode not cleared");

  // Same-cycle edge beats a software acknowledge
  property p_edge_priority; // R26
    @(posedge ref_clk) disable iff (!rst_n)
    ce && fall_two && request_clear_two |=> pending_flag_two;
  endproperty
  a_edge_priority: assert property (p_edge_priority) // R26
    else $error("edge lost against acknowledge");

  // Mask gates the CPU request two cycles on
  property p_mask_gate; // R23
    @(posedge ref_clk) disable iff (!rst_n)
    ce && pending_flag_one && request_mask_one_r && !wr_status
      ##1 ce |=> !cpu_req_one_r;
  endproperty
  a_mask_gate: assert property (p_mask_gate) // R23
    else $error("masked request reached the CPU");

  // Unmasked request raises wake the next cycle
  property p_wake; // R15
    @(posedge ref_clk) disable iff (!rst_n)
    ce && pending_flag_two && !request_mask_two_r |=> wake_req_r;
  endproperty
  a_wake: assert property (p_wake) // R16
    else $error("wake not raised");

  // Break without enable protects the flag
  property p_break_protect; // R18
    @(posedge ref_clk) disable iff (!rst_n)
    ce && break_state && !break_clear_enable_r && request_clear_one && !trigger_select_one_r
      && !vector_fetch_one && pending_flag_one |=> pending_flag_one;
  endproperty
  a_break_protect: assert property (p_break_protect) // R18
    else $error("flag cleared in protected break");

  // Break clear stays cleared after break ends
  property p_break_clear; // R17
    @(posedge ref_clk) disable iff (!rst_n)
    ce && break_state && break_clear_enable_r && request_clear_two
      && lvl_two && prev_two ##1 ce && lvl_two && !break_state
      |-> !pending_flag_two;
  endproperty
  a_break_clear: assert property (p_break_clear) // R17
    else $error("break clear not kept");

  // Acknowledge bits read back as zero
  property p_ack_read_zero; // R19
    @(posedge ref_clk) disable iff (!rst_n)
    ce && bus_rd |=> !bus_rdata_r[deil_pkg::REQUEST_CLEAR_ONE_POS]
      && !bus_rdata_r[deil_pkg::REQUEST_CLEAR_TWO_POS];
  endproperty
  a_ack_read_zero: assert property (p_ack_read_zero) // R19
    else $error("acknowledge bit read as one");

  // Flag read shows the latched request
  property p_flag_read; // R06
    @(posedge ref_clk) disable iff (!rst_n)
    ce && bus_rd && (bus_addr == deil_pkg::EXT_INT_STATUS_CONTROL_OFS)
      |=> bus_rdata_r[deil_pkg::PENDING_FLAG_ONE_POS] == $past(pending_flag_one)
      && bus_rdata_r[deil_pkg::PENDING_FLAG_TWO_POS] == $past(pending_flag_two);
  endproperty
  a_flag_read: assert property (p_flag_read) // R22
    else $error("pending flag misread");

  // Mirror of pin two after acknowledge in level mode
  property p_two_mirror; // R14
    @(posedge ref_clk) disable iff (!rst_n)
    ce && trigger_select_two_r && ack_two
      |=> pending_flag_two == !$past(lvl_two);
  endproperty
  a_two_mirror: assert property (p_two_mirror) // R14
    else $error("pin two flag not inverse of level");

  // Pin one level output follows the sampled pin
  property p_level_out; // R07
    @(posedge ref_clk) disable iff (!rst_n)
    ce |=> pin_one_level_r == $past(lvl_one);
  endproperty
  a_level_out: assert property (p_level_out) // R07
    else $error("pin level output stale");

endmodule

/* bench/deil_far_side.sv */
/*
  Far side of the external interrupt latch: the two signal sources that
  drive the pins and the CPU logic that fetches vectors.
  Assumes the bench calls its tasks one at a time on ref_clk.
*/
`timescale 1ns/1ps

module deil_far_side (
  input  wire logic ref_clk,
  input  wire logic cpu_req_one_r,
  output logic      pin_one_n,
  output logic      pin_two_n,
  output logic      fetch_one,
  output logic      fetch_two
);
  logic       auto_en;
  logic [2:0] hold_r;
  int         n_fetch;

  initial begin
    pin_one_n = 1'b1;
    pin_two_n = 1'b1;
    fetch_one = 1'b0;
    fetch_two = 1'b0;
    auto_en   = 1'b0;
    hold_r    = 3'h0;
    n_fetch   = 0;
  end

  // **********************************
  // Pin sources
  // **********************************
  task automatic drive(input int p, input logic v);
    @(posedge ref_clk);
    if (p == 0) begin
      pin_one_n <= v;
    end else begin
      pin_two_n <= v;
    end
  endtask

  // Slow vector fetch after a chosen delay
  task automatic fetch(input int p, input int dly);
    repeat (dly) @(posedge ref_clk);
    if (p == 0) begin
      fetch_one <= 1'b1;
    end else begin
      fetch_two <= 1'b1;
    end
    @(posedge ref_clk);
    fetch_one <= 1'b0;
    fetch_two <= 1'b0;
  endtask

  // **********************************
  // Prompt CPU service of pin one
  // **********************************
  always @(posedge ref_clk) begin
    if (auto_en && cpu_req_one_r && hold_r == 3'h0) begin
      fetch_one <= 1'b1;
      hold_r    <= 3'h4;
      n_fetch   <= n_fetch + 1;
    end else if (auto_en) begin
      fetch_one <= 1'b0;
      if (hold_r != 3'h0) begin
        hold_r <= hold_r - 3'h1;
      end
    end
  end
endmodule

/* bench/dual_external_interrupt_latch_bench.sv */
/*
  Self-checking bench for the dual external interrupt latch: register
  tasks, pin and fetch stimulus through the far side model.
  Assumes fixed pin-to-flag latency of three edges and no bus stalls.
*/
`timescale 1ns/1ps

module dual_external_interrupt_latch_bench;
  logic       ref_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic       ce      = 1'b1;
  logic [1:0] bus_addr  = 2'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic       bus_wr = 1'b0;
  logic       bus_rd = 1'b0;
  logic       break_state = 1'b0;
  logic       pin_one_n, pin_two_n, fetch_one, fetch_two;
  logic [7:0] bus_rdata_r;
  logic       cpu_req_one_r, cpu_req_two_r, wake_req_r, pin_one_level_r;
  logic [7:0] d;
  int         n_mismatch = 0;
  int         checks     = 0;

  always #4 ref_clk = ~ref_clk;

  deil_ext_int DUT (
    .ref_clk           (ref_clk),
    .rst_n             (rst_n),
    .ce                (ce),
    .ext_int_pin_one_n (pin_one_n),
    .ext_int_pin_two_n (pin_two_n),
    .bus_addr          (bus_addr),
    .bus_wdata         (bus_wdata),
    .bus_wr            (bus_wr),
    .bus_rd            (bus_rd),
    .vector_fetch_one  (fetch_one),
    .vector_fetch_two  (fetch_two),
    .break_state       (break_state),
    .bus_rdata_r       (bus_rdata_r),
    .cpu_req_one_r     (cpu_req_one_r),
    .cpu_req_two_r     (cpu_req_two_r),
    .wake_req_r        (wake_req_r),
    .pin_one_level_r   (pin_one_level_r)
  );

  deil_far_side far (
    .ref_clk       (ref_clk),
    .cpu_req_one_r (cpu_req_one_r),
    .pin_one_n     (pin_one_n),
    .pin_two_n     (pin_two_n),
    .fetch_one     (fetch_one),
    .fetch_two     (fetch_two)
  );

  // **********************************
  // Bus tasks and checks
  // **********************************
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    bus_addr  <= a;
    bus_wdata <= v;
    bus_wr    <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata_r;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rchk(input string name, input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(name, exp, v);
  endtask

  task automatic conclude;
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // **********************************
  // One pin through edge and level modes
  // **********************************
  task automatic test_pin(input int p);
    logic [7:0] sel, msk, ack, flg;
    logic       req;
    sel = 8'h01 << (4 * p);
    msk = 8'h02 << (4 * p);
    ack = 8'h04 << (4 * p);
    flg = 8'h08 << (4 * p);
    wr(0, 8'h00);
    far.drive(p, 1'b0);
    idle(5);
    rchk("flag_edge", 0, flg);
    req = (p == 0) ? cpu_req_one_r : cpu_req_two_r;
    chk("cpu_req", 8'h01, {7'h00, req});
    chk("wake", 8'h01, {7'h00, wake_req_r});
    if (p == 0) begin
      chk("pin_level", 8'h00, {7'h00, pin_one_level_r});
    end
    wr(0, msk);
    idle(3);
    rchk("flag_masked", 0, flg | msk);
    req = (p == 0) ? cpu_req_one_r : cpu_req_two_r;
    chk("req_masked", 8'h00, {7'h00, req});
    chk("wake_masked", 8'h00, {7'h00, wake_req_r});
    wr(0, msk | ack);
    idle(2);
    rchk("ack_edge", 0, msk);
    far.drive(p, 1'b1);
    idle(3);
    far.drive(p, 1'b0);
    idle(5);
    rchk("fresh_edge", 0, flg | msk);
    wr(0, 8'h00);
    far.fetch(p, 3);
    idle(3);
    rchk("fetch_clear", 0, 8'h00);
    wr(0, sel);
    idle(5);
    rchk("level_low", 0, sel | flg);
    wr(0, sel | ack);
    idle(3);
    rchk("level_ack_low", 0, sel | flg);
    far.drive(p, 1'b1);
    idle(5);
    rchk("level_high", 0, sel);
    far.drive(p, 1'b0);
    idle(5);
    far.drive(p, 1'b1);
    idle(5);
    rchk("level_wait_ack", 0, sel | flg);
    wr(0, sel | ack);
    idle(3);
    rchk("level_ack_high", 0, sel);
    wr(0, 8'h00);
  endtask

  // **********************************
  // Main sequence
  // **********************************
  initial begin
    idle(6);
    rst_n <= 1'b1;
    rchk("status_rst", 0, 8'h00);
    rchk("break_rst", 1, 8'h00);
    chk("pin_level_rst", 8'h01, {7'h00, pin_one_level_r});
    wr(0, 8'hff);
    rchk("ctrl_rw", 0, 8'h33);
    wr(0, 8'h22);
    rchk("mask_rw", 0, 8'h22);
    wr(0, 8'h11);
    rchk("select_rw", 0, 8'h11);
    wr(2, 8'hff);
    rchk("unmapped_wr", 0, 8'h11);
    rchk("unmapped_rd", 3, 8'h00);
    test_pin(0);
    test_pin(1);
    far.drive(0, 1'b0);
    far.drive(1, 1'b0);
    idle(5);
    rchk("both_pins", 0, 8'h88);
    break_state <= 1'b1;
    wr(0, 8'h44);
    rchk("break_protect", 0, 8'h88);
    wr(1, 8'h80);
    rchk("break_enable", 1, 8'h80);
    wr(0, 8'h44);
    break_state <= 1'b0;
    idle(3);
    rchk("break_cleared", 0, 8'h00);
    wr(1, 8'h00);
    far.drive(0, 1'b1);
    far.drive(1, 1'b1);
    far.auto_en = 1'b1;
    idle(3);
    far.drive(0, 1'b0);
    idle(12);
    chk("auto_fetch", 8'h01, far.n_fetch[7:0]);
    rchk("auto_clear", 0, 8'h00);
    far.auto_en = 1'b0;
    far.drive(1, 1'b0);
    idle(1);
    wr(0, 8'h40);
    idle(2);
    rchk("edge_beats_ack", 0, 8'h80);
    wr(0, 8'h11);
    idle(5);
    chk("req_before_rst", 8'h01, {7'h00, cpu_req_two_r});
    rst_n <= 1'b0;
    idle(2);
    chk("req_in_reset", 8'h00, {7'h00, cpu_req_two_r});
    rst_n <= 1'b1;
    rd(0, d);
    chk("select_after_rst", 8'h00, d & 8'h33);
    conclude();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end
endmodule
